// [hrl_byte_pair.sv]
// assembles two hex characters into a byte
`timescale 1ns/100ps
`include "hrl_regs.svh"
module hrl_byte_pair (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	// character side
	input wire logic clear_in,
	input wire logic nib_valid_in,
	input wire logic [3:0] nib_in,
	// byte side
	output logic byte_valid_out,
	output logic [7:0] byte_out
);
	logic have_hi;
	logic [3:0] hi;
	logic next_have_hi;
	logic [3:0] next_hi;
	logic next_byte_valid;
	logic [7:0] next_byte;
	always_comb begin
		next_have_hi = have_hi;
		next_hi = hi;
		next_byte_valid = 1'b0;
		next_byte = byte_out;
		if (clear_in) begin
			next_have_hi = 1'b0;
		end else if (nib_valid_in) begin
			if (!have_hi) begin
				next_hi = nib_in;
				next_have_hi = 1'b1;
			end else begin
				next_byte = {hi, nib_in};
				next_byte_valid = 1'b1;
				next_have_hi = 1'b0;
			end
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			have_hi <= 1'b0;
			hi <= 4'h0;
			byte_valid_out <= 1'b0;
			byte_out <= 8'h00;
		end else begin
			have_hi <= next_have_hi;
			hi <= next_hi;
			byte_valid_out <= next_byte_valid;
			byte_out <= next_byte;
		end
	end
	AST_PAIR_HI: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in) nib_valid_in && !clear_in && have_hi |=>
		byte_valid_out && byte_out[7:4] == $past(hi)
		&& byte_out[3:0] == $past(nib_in))
		else $error("byte not built from nibble pair");
endmodule

// [hrl_host.sv]
// host model that downloads hex load records at most one character per cycle
`timescale 1ns/100ps
module hrl_host (
	// clock
	input wire logic clk_sys_in,
	// character stream
	output logic char_valid_out,
	output logic [7:0] char_out
);
	initial begin
		char_valid_out = 1'b0;
		char_out = 8'h00;
	end

	// gap inserts idle cycles after each character, as a slow host would
	task automatic send_str(input string s, input int gap);
		for (int i = 0; i < s.len(); i++) begin
			@(posedge clk_sys_in);
			char_valid_out <= 1'b1;
			char_out <= s[i];
			repeat (gap) begin
				@(posedge clk_sys_in);
				char_valid_out <= 1'b0;
				char_out <= ~s[i];
			end
		end
		@(posedge clk_sys_in);
		char_valid_out <= 1'b1;
		char_out <= 8'h0d;
		@(posedge clk_sys_in);
		char_valid_out <= 1'b0;
		// idle line must not look like a held character
		char_out <= 8'hf2;
	endtask
endmodule

// [hrl_loader.sv]
// hex record stream parser and memory write generator
`timescale 1ns/100ps
`include "hrl_regs.svh"
// Overview of operation
// - each byte arrives as two hex characters, upper nibble first.
// - fields come as type, length, address, data, checksum in order.
// - the length counts the byte pairs after it, checksum included.
// - the address is 2, 3 or 4 bytes wide as the type selects.
// - any data byte count from zero to 255 less the address and checksum bytes is accepted.
// - the checksum is the inverted low byte of the field sum.
// - characters before the start letter are discarded.
// - header records are reported and never written to memory.
// - types 1, 2, 3 load data bytes at consecutive addresses.
// - the count record carries the record count in its address.
// - types 7, 8, 9 end a block and carry an entry address.
// - more than one header record in a stream is accepted.
// - characters are 8-bit ASCII codes.
module hrl_loader
	import hrl_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	// character stream
	input wire logic char_valid_in,
	input wire logic [7:0] char_in,
	// memory writes
	output logic wr_en_out,
	output logic [31:0] wr_addr_out,
	output logic [7:0] wr_data_out,
	// record reports
	output logic header_out,
	output logic count_out,
	output logic [31:0] count_value_out,
	output logic end_out,
	output logic [31:0] entry_addr_out,
	output logic rec_ok_out,
	output logic error_out
);
	// writes are held until the checksum passes, so a record is buffered
	localparam int MAX_BYTES = 255;
	hrl_state_t state, next_state;
	logic [3:0] rtype, next_rtype;
	logic [7:0] remain, next_remain;
	logic [2:0] abytes, next_abytes;
	logic [2:0] acnt, next_acnt;
	logic [31:0] addr, next_addr;
	logic [7:0] sum, next_sum;
	logic [7:0] ndata, next_ndata;
	logic [7:0] widx, next_widx;
	logic bad, next_bad;
	logic nv, is_hex, clr, bv;
	logic [3:0] nib;
	logic [7:0] bval, rd_data, next_wr_data;
	logic [7:0] buf_mem [0:MAX_BYTES-1];
	logic next_wr_en, next_header, next_count, next_end, next_ok, next_err;
	logic [31:0] next_wr_addr, next_count_val, next_entry;
	logic wr_pend, next_wr_pend;

	function automatic logic [4:0] hex_val(input logic [7:0] c);
		if (c >= `HRL_CH_0 && c <= `HRL_CH_9)
			hex_val = {1'b1, c[3:0]};
		else if ((c >= `HRL_CH_UA && c <= `HRL_CH_UF) ||
			(c >= `HRL_CH_LA && c <= `HRL_CH_LF))
			hex_val = {1'b1, c[3:0] + `HRL_HEX_LETTER};
		else
			hex_val = 5'h00;
	endfunction
	function automatic logic [2:0] addr_width(input logic [3:0] t);
		case (t)
			`HRL_TY_D24, `HRL_TY_E24: addr_width = `HRL_AB_3;
			`HRL_TY_D32, `HRL_TY_E32: addr_width = `HRL_AB_4;
			default: addr_width = `HRL_AB_2;
		endcase
	endfunction
	function automatic logic is_data(input logic [3:0] t);
		is_data = (t == `HRL_TY_D16) || (t == `HRL_TY_D24) ||
			(t == `HRL_TY_D32);
	endfunction
	assign {is_hex, nib} = hex_val(char_in);
	assign nv = char_valid_in && is_hex &&
		(state == HRL_LEN || state == HRL_ADDR || state == HRL_DATA);
	assign clr = (state == HRL_IDLE) || (state == HRL_TYPE);

	hrl_byte_pair u_pair (
		.clk_sys_in(clk_sys_in),
		.rstn_in(rstn_in),
		.clear_in(clr),
		.nib_valid_in(nv),
		.nib_in(nib),
		.byte_valid_out(bv),
		.byte_out(bval)
	);

	// buffer: writes on data bytes, read register feeds the write port
	always_ff @(posedge clk_sys_in) begin
		if (bv && state == HRL_DATA && remain > `HRL_ONE8)
			buf_mem[ndata] <= bval;
		rd_data <= buf_mem[next_widx];
	end

	always_comb begin
		next_state = state;
		next_rtype = rtype;
		next_remain = remain;
		next_abytes = abytes;
		next_acnt = acnt;
		next_addr = addr;
		next_sum = sum;
		next_ndata = ndata;
		next_widx = widx;
		next_bad = bad;
		next_wr_pend = 1'b0;
		next_wr_en = 1'b0;
		next_wr_addr = wr_addr_out;
		next_wr_data = wr_data_out;
		next_header = 1'b0;
		next_count = 1'b0;
		next_count_val = count_value_out;
		next_end = 1'b0;
		next_entry = entry_addr_out;
		next_ok = 1'b0;
		next_err = 1'b0;
		if (char_valid_in && char_in == `HRL_CH_START &&
			state != HRL_WAIT) begin
			next_state = HRL_TYPE;
			next_bad = 1'b0;
		end else begin
			case (state)
			HRL_IDLE: next_state = HRL_IDLE; // drop until start
			HRL_TYPE: if (char_valid_in) begin
				next_rtype = char_in[3:0];
				next_abytes = addr_width(char_in[3:0]);
				next_acnt = 3'h0;
				next_addr = 32'h0;
				next_sum = 8'h00;
				next_ndata = 8'h00;
				next_bad = !is_hex || char_in[7:4] != `HRL_HEX_HI;
				next_state = HRL_LEN;
			end
			HRL_LEN: begin
				if (char_valid_in && !is_hex) next_bad = 1'b1;
				if (bv) begin
					next_remain = bval;
					next_sum = bval;
					// length must cover address and checksum
					if (bval < {5'h00, abytes} + `HRL_ONE8) next_bad = 1'b1;
					next_state = HRL_ADDR;
				end
			end
			HRL_ADDR: begin
				if (char_valid_in && !is_hex && char_in != `HRL_CH_CR)
					next_bad = 1'b1;
				if (bv) begin
					next_addr = {addr[23:0], bval};
					next_sum = sum + bval;
					next_remain = remain - `HRL_ONE8;
					next_acnt = acnt + 3'h1;
					if (acnt + 3'h1 == abytes) next_state = HRL_DATA;
				end
			end
			HRL_DATA: begin
				if (char_valid_in && !is_hex && char_in != `HRL_CH_CR)
					next_bad = 1'b1;
				if (bv) begin
					next_sum = sum + bval;
					next_remain = remain - `HRL_ONE8;
					if (remain > `HRL_ONE8)
						next_ndata = ndata + `HRL_ONE8;
				end
				if (char_valid_in && char_in == `HRL_CH_CR) begin
					next_widx = 8'h00;
					next_state = HRL_IDLE;
					// checksum byte may complete in this very cycle
					if (bad || next_remain != 8'h00 ||
						next_sum != `HRL_CKSUM_OK) begin
						next_err = 1'b1;
					end else begin
						next_ok = 1'b1;
						case (rtype)
						`HRL_TY_HDR: next_header = 1'b1;
						`HRL_TY_CNT: begin
							next_count = 1'b1;
							next_count_val = addr;
						end
						`HRL_TY_E32, `HRL_TY_E24, `HRL_TY_E16: begin
							next_end = 1'b1;
							next_entry = addr;
						end
						default: begin
							if (is_data(rtype) && ndata != 8'h00) begin
								next_state = HRL_WAIT;
								next_wr_pend = 1'b1;
							end
						end
						endcase
					end
				end
			end
			HRL_WAIT: begin
				// incoming characters are ignored while the record drains
				if (wr_pend) begin
					next_wr_en = 1'b1;
					next_wr_addr = addr;
					next_wr_data = rd_data;
					next_addr = addr + `HRL_ONE32;
					next_widx = widx + `HRL_ONE8;
				end
				if (widx + `HRL_ONE8 < ndata)
					next_wr_pend = 1'b1;
				else if (!wr_pend)
					next_state = HRL_IDLE;
			end
			default: next_state = HRL_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			state <= HRL_IDLE;
			rtype <= 4'h0;
			remain <= 8'h00;
			abytes <= 3'h0;
			acnt <= 3'h0;
			addr <= 32'h0;
			sum <= 8'h00;
			ndata <= 8'h00;
			widx <= 8'h00;
			bad <= 1'b0;
			wr_pend <= 1'b0;
			wr_en_out <= 1'b0;
			wr_addr_out <= 32'h0;
			wr_data_out <= 8'h00;
			header_out <= 1'b0;
			count_out <= 1'b0;
			count_value_out <= 32'h0;
			end_out <= 1'b0;
			entry_addr_out <= 32'h0;
			rec_ok_out <= 1'b0;
			error_out <= 1'b0;
		end else begin
			state <= next_state;
			rtype <= next_rtype;
			remain <= next_remain;
			abytes <= next_abytes;
			acnt <= next_acnt;
			addr <= next_addr;
			sum <= next_sum;
			ndata <= next_ndata;
			widx <= next_widx;
			bad <= next_bad;
			wr_pend <= next_wr_pend;
			wr_en_out <= next_wr_en;
			wr_addr_out <= next_wr_addr;
			wr_data_out <= next_wr_data;
			header_out <= next_header;
			count_out <= next_count;
			count_value_out <= next_count_val;
			end_out <= next_end;
			entry_addr_out <= next_entry;
			rec_ok_out <= next_ok;
			error_out <= next_err;
		end
	end

	AST_NO_WRITE_ON_ERR: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in) error_out |-> !wr_en_out)
		else $error("write during error report");
	AST_ADDR_STEP: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in) wr_en_out && $past(wr_en_out) |->
		wr_addr_out == $past(wr_addr_out) + `HRL_ONE32)
		else $error("write address did not step");
	AST_HDR_NO_WRITE: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in) header_out |-> rec_ok_out && !wr_en_out)
		else $error("header record misreported");
	AST_END_OK: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in) end_out |-> rec_ok_out && !error_out)
		else $error("end record without valid checksum");
	AST_COUNT_OK: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in) count_out |-> rec_ok_out
		&& count_value_out == $past(addr))
		else $error("count value mismatch");
	AST_CKSUM: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in) rec_ok_out |-> sum == `HRL_CKSUM_OK)
		else $error("record accepted with bad checksum");
	AST_START: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in) state == HRL_IDLE && char_valid_in
		&& char_in != `HRL_CH_START |=> state == HRL_IDLE)
		else $error("left idle without start letter");
	AST_WIDTH: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in) state == HRL_TYPE && char_valid_in &&
		char_in == {`HRL_HEX_HI, `HRL_TY_D32} |=> abytes == `HRL_AB_4)
		else $error("address width wrong for long type");
endmodule

// [hrl_pkg.sv]
// types for the hex record loader
package hrl_pkg;
	typedef enum logic [2:0] {
		HRL_IDLE = 3'h0,
		HRL_TYPE = 3'h1,
		HRL_LEN = 3'h3,
		HRL_ADDR = 3'h2,
		HRL_DATA = 3'h6,
		HRL_WAIT = 3'h7,
		HRL_SKIP = 3'h5
	} hrl_state_t;
endpackage

// [hrl_regs.svh]
// constants for the hex record loader
`ifndef HRL_REGS_SVH
`define HRL_REGS_SVH
`define HRL_CH_START 8'h53
`define HRL_CH_CR 8'h0d
`define HRL_CH_0 8'h30
`define HRL_CH_9 8'h39
`define HRL_CH_UA 8'h41
`define HRL_CH_UF 8'h46
`define HRL_CH_LA 8'h61
`define HRL_CH_LF 8'h66
`define HRL_HEX_HI 4'h3
`define HRL_HEX_LETTER 4'h9
`define HRL_TY_HDR 4'h0
`define HRL_TY_D16 4'h1
`define HRL_TY_D24 4'h2
`define HRL_TY_D32 4'h3
`define HRL_TY_CNT 4'h5
`define HRL_TY_E32 4'h7
`define HRL_TY_E24 4'h8
`define HRL_TY_E16 4'h9
`define HRL_AB_2 3'h2
`define HRL_AB_3 3'h3
`define HRL_AB_4 3'h4
`define HRL_CKSUM_OK 8'hff
`define HRL_ONE8 8'h01
`define HRL_ONE32 32'h00000001
`endif

// [test_hrl_loader.sv]
// self-checking bench for the hex record loader
`timescale 1ns/100ps
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin \
	bad_count++; $display("MISMATCH %0t %s", $time, m); end end
module test_hrl_loader;
	typedef logic [45:0] hrl_ev_t;
	logic clk_sys_in = 1'b0;
	logic rstn_in = 1'b0;
	logic char_valid_in;
	logic [7:0] char_in;
	logic wr_en_out;
	logic [31:0] wr_addr_out;
	logic [7:0] wr_data_out;
	logic header_out;
	logic count_out;
	logic [31:0] count_value_out;
	logic end_out;
	logic [31:0] entry_addr_out;
	logic rec_ok_out;
	logic error_out;
	hrl_ev_t exp_q[$];
	hrl_ev_t ev;
	int bad_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [15:0] lfsr = 16'h4a98;

	always #25 clk_sys_in = ~clk_sys_in;

	hrl_host i_hrl_host (
		.clk_sys_in(clk_sys_in),
		.char_valid_out(char_valid_in),
		.char_out(char_in)
	);

	hrl_loader i_hrl_loader (
		.clk_sys_in(clk_sys_in),
		.rstn_in(rstn_in),
		.char_valid_in(char_valid_in),
		.char_in(char_in),
		.wr_en_out(wr_en_out),
		.wr_addr_out(wr_addr_out),
		.wr_data_out(wr_data_out),
		.header_out(header_out),
		.count_out(count_out),
		.count_value_out(count_value_out),
		.end_out(end_out),
		.entry_addr_out(entry_addr_out),
		.rec_ok_out(rec_ok_out),
		.error_out(error_out)
	);

	function automatic logic [7:0] rnd8();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr[7:0];
	endfunction

	function automatic byte hx(input logic [3:0] n);
		return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
	endfunction

	function automatic string hb(input logic [7:0] v);
		string r;
		r = "00";
		r.putc(0, hx(v[7:4]));
		r.putc(1, hx(v[3:0]));
		return r;
	endfunction

	// bad: 0 good, 1 checksum off, 2 non-hex digit, 3 length too short
	task automatic send_rec(input logic [3:0] ty, input int ab,
			input logic [31:0] addr, input int n, input int bad,
			input int gap, input string pre);
		string s;
		logic [7:0] len;
		logic [7:0] sum;
		logic [7:0] b;
		logic [31:0] a;
		logic dat;
		dat = (ty == 4'h1 || ty == 4'h2 || ty == 4'h3);
		a = addr;
		if (ab < 4)
			a = addr & ((32'h1 << (8 * ab)) - 32'h1);
		s = "S0";
		s.putc(1, hx(ty));
		len = 8'(ab + n + 1);
		if (bad == 3)
			len = 8'(ab);
		s = {pre, s, hb(len)};
		sum = len;
		for (int i = ab - 1; i >= 0; i--) begin
			b = a[8 * i +: 8];
			sum += b;
			s = {s, hb(b)};
		end
		if (bad != 0)
			exp_q.push_back({6'b010000, 40'h0});
		else if (dat)
			exp_q.push_back({6'b001000, 40'h0});
		else if (ty == 4'h0)
			exp_q.push_back({6'b001100, 40'h0});
		else if (ty == 4'h5)
			exp_q.push_back({6'b001010, a, 8'h00});
		else
			exp_q.push_back({6'b001001, a, 8'h00});
		for (int i = 0; i < n; i++) begin
			b = rnd8();
			sum += b;
			s = {s, hb(b)};
			if (bad == 0 && dat)
				exp_q.push_back({6'b100000, a, b});
			a++;
		end
		sum = ~sum;
		if (bad == 1)
			sum ^= 8'h01;
		s = {s, hb(sum)};
		if (bad == 2)
			s.putc(pre.len() + 5, "G");
		i_hrl_host.send_str(s, gap);
		// writes drain before the next record may start
		repeat (n + 6) @(posedge clk_sys_in);
	endtask

	task automatic end_sim();
		$display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// watcher: each reported result takes the oldest note
	always @(posedge clk_sys_in) begin
		ev = {wr_en_out, error_out, rec_ok_out, header_out, count_out,
			end_out, 40'h0};
		if (wr_en_out === 1'b1)
			ev[39:0] = {wr_addr_out, wr_data_out};
		else if (count_out === 1'b1)
			ev[39:8] = count_value_out;
		else if (end_out === 1'b1)
			ev[39:8] = entry_addr_out;
		if (rstn_in === 1'b1 && ev[45:40] !== 6'b000000) begin
			if (exp_q.size() == 0) begin
				bad_count++;
				$display("MISMATCH %0t unexpected output", $time);
			end else
				`CHK(ev, exp_q.pop_front(), "record output")
		end
	end

	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 8000) begin
			bad_count++;
			$display("MISMATCH %0t run timed out", $time);
			end_sim();
		end
	end

	initial begin
		repeat (4) @(posedge clk_sys_in);
		rstn_in <= 1'b1;
		send_rec(4'h1, 2, {rnd8(), rnd8(), rnd8(), rnd8()}, 3, 0, 0, "12 ");
		$display("test leading field done");
		send_rec(4'h0, 2, 32'h0, 3, 0, 0, "");
		send_rec(4'h0, 2, 32'h0, 2, 0, 1, "");
		$display("test headers done");
		send_rec(4'h2, 3, {rnd8(), rnd8(), rnd8(), rnd8()}, 28, 0, 0, "");
		send_rec(4'h3, 4, {rnd8(), rnd8(), rnd8(), rnd8()}, 0, 0, 0, "");
		send_rec(4'h3, 4, {rnd8(), rnd8(), rnd8(), rnd8()}, 5, 0, 1, "");
		$display("test data widths done");
		for (int k = 1; k <= 3; k++)
			send_rec(4'h1, 2, {rnd8(), rnd8(), rnd8(), rnd8()}, 2, k, 0, "");
		send_rec(4'h5, 2, 32'h0004, 0, 0, 0, "");
		$display("test errors and count done");
		// each block is closed by one termination of its own width
		for (int k = 0; k < 3; k++) begin
			send_rec(4'(3 - k), 4 - k, {rnd8(), rnd8(), rnd8(), rnd8()},
				2, 0, 0, "");
			send_rec(4'(7 + k), 4 - k, {rnd8(), rnd8(), rnd8(), rnd8()},
				0, 0, 0, "");
		end
		$display("test terminations done");
		repeat (10) @(posedge clk_sys_in);
		`CHK(exp_q.size(), 0, "results missing")
		end_sim();
	end
endmodule
